// file: hdl/sram_defines.svh
`ifndef SRAM_DEFINES_SVH
`define SRAM_DEFINES_SVH

`define SRAM_LANES 4
`define SRAM_LANE_W 9
`define SRAM_DATA_W 36
`define SRAM_ADDR_W 18
`define SRAM_LOW_W 2
`define SRAM_ADDR_W_MIN 3
`define SRAM_ADDR_W_MAX 20
`define SRAM_LANES_ALL 4'hF
`define SRAM_LANES_NONE 4'h0
`define SRAM_RST_OE_N 1'b1
`define SRAM_RST_SLEEP 1'b0
`define SRAM_RST_ORDER 1'b1
`define SRAM_ASYNC_OE 0
`define SRAM_ASYNC_SLEEP 1
`define SRAM_ASYNC_ORDER 2

`endif

// file: hdl/sram_pkg.sv
`include "sram_defines.svh"

package sram_pkg;

  typedef logic [`SRAM_LOW_W-1:0] low_t;
  typedef logic [`SRAM_LANES-1:0] lane_mask_t;

  typedef enum logic {
    ST_DESEL,
    ST_ACTIVE
  } cycle_t;

  // linear adds the count, interleaved folds it in with exclusive-or
  function automatic low_t burst_low(input low_t base, input low_t cnt, input logic linear);
    burst_low = linear ? low_t'(base + cnt) : (base ^ cnt);
  endfunction

endpackage

// file: hdl/burst_counter.sv
`timescale 1ns/100ps
`default_nettype none

module burst_counter
  import sram_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire low_t load_low_i,
  input wire logic step_i,
  input wire logic linear_i,
  output low_t low_o,
  output low_t next_low_o
);

  low_t base_q;
  low_t cnt_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      base_q <= '0;
      cnt_q <= '0;
    end else if (load_i) begin
      base_q <= load_low_i;
      cnt_q <= '0;
    end else if (step_i) begin
      cnt_q <= low_t'(cnt_q + 2'h1);
    end
  end

  assign low_o = burst_low(base_q, cnt_q, linear_i);
  assign next_low_o = burst_low(base_q, low_t'(cnt_q + 2'h1), linear_i);

  a_linear_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (step_i && !load_i && linear_i && $stable(linear_i)) |=> low_o == low_t'($past(low_o) + 2'h1))
    else $error("linear burst did not count up by one");

  a_interleave_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (step_i && !load_i && !linear_i && $stable(linear_i)) |=> low_o == (base_q ^ low_t'($past(cnt_q) + 2'h1)))
    else $error("interleaved burst sequence wrong");

endmodule

`default_nettype wire

// file: hdl/sync_burst_sram_pin_control.sv
`timescale 1ns/100ps
`default_nettype none

`include "sram_defines.svh"

module sync_burst_sram_pin_control
  import sram_pkg::*;
#(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter bit HAS_THIRD_SELECT = 1'b1
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic CHIP_SELECT_N_I,
  input wire logic SECOND_SELECT_HI_I,
  input wire logic THIRD_SELECT_N_I,
  input wire logic PROC_ADDR_STROBE_N_I,
  input wire logic CTRL_ADDR_STROBE_N_I,
  input wire logic BURST_STEP_N_I,
  input wire logic LANE0_WRITE_N_I,
  input wire logic LANE1_WRITE_N_I,
  input wire logic LANE2_WRITE_N_I,
  input wire logic LANE3_WRITE_N_I,
  input wire logic BYTE_WRITE_GATE_N_I,
  input wire logic ALL_LANES_WRITE_N_I,
  input wire logic OUTPUT_ENABLE_N_I,
  input wire logic BURST_ORDER_I,
  input wire logic SLEEP_REQUEST_I,
  input wire logic [`SRAM_DATA_W-1:0] DATA_I,
  output logic [`SRAM_DATA_W-1:0] DATA_O,
  output logic [`SRAM_LANES-1:0] DATA_OE_O
);

  localparam int DEPTH = 1 << ADDR_W;

  if (ADDR_W < `SRAM_ADDR_W_MIN || ADDR_W > `SRAM_ADDR_W_MAX) begin : g_bad_addr_w
    $error("ADDR_W out of supported range");
  end

  // pin capture stage: every synchronous input is sampled together
  logic [ADDR_W-1:0] cap_addr_q;
  logic [`SRAM_DATA_W-1:0] cap_data_q;
  logic cap_ce_n_q;
  logic cap_sel2_q;
  logic cap_sel3_n_q;
  logic cap_pstrb_n_q;
  logic cap_cstrb_n_q;
  logic cap_step_n_q;
  lane_mask_t cap_bw_n_q;
  logic cap_gate_n_q;
  logic cap_allw_n_q;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cap_addr_q <= '0;
      cap_data_q <= '0;
      cap_ce_n_q <= 1'b1;
      cap_sel2_q <= 1'b0;
      cap_sel3_n_q <= 1'b1;
      cap_pstrb_n_q <= 1'b1;
      cap_cstrb_n_q <= 1'b1;
      cap_step_n_q <= 1'b1;
      cap_bw_n_q <= `SRAM_LANES_ALL;
      cap_gate_n_q <= 1'b1;
      cap_allw_n_q <= 1'b1;
    end else begin
      cap_addr_q <= ADDR_I;
      cap_data_q <= DATA_I;
      cap_ce_n_q <= CHIP_SELECT_N_I;
      cap_sel2_q <= SECOND_SELECT_HI_I;
      cap_sel3_n_q <= THIRD_SELECT_N_I;
      cap_pstrb_n_q <= PROC_ADDR_STROBE_N_I;
      cap_cstrb_n_q <= CTRL_ADDR_STROBE_N_I;
      cap_step_n_q <= BURST_STEP_N_I;
      cap_bw_n_q <= {LANE3_WRITE_N_I, LANE2_WRITE_N_I, LANE1_WRITE_N_I, LANE0_WRITE_N_I};
      cap_gate_n_q <= BYTE_WRITE_GATE_N_I;
      cap_allw_n_q <= ALL_LANES_WRITE_N_I;
    end
  end

  // asynchronous pins pass two flops; costs two cycles of enable and sleep latency
  logic [2:0] async_meta_q;
  logic [2:0] async_q;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      async_meta_q <= {`SRAM_RST_ORDER, `SRAM_RST_SLEEP, `SRAM_RST_OE_N};
      async_q <= {`SRAM_RST_ORDER, `SRAM_RST_SLEEP, `SRAM_RST_OE_N};
    end else begin
      async_meta_q <= {BURST_ORDER_I, SLEEP_REQUEST_I, OUTPUT_ENABLE_N_I};
      async_q <= async_meta_q;
    end
  end

  logic oe_n;
  logic sleep;
  logic linear;

  assign oe_n = async_q[`SRAM_ASYNC_OE];
  assign sleep = async_q[`SRAM_ASYNC_SLEEP];
  assign linear = !async_q[`SRAM_ASYNC_ORDER];

  // cycle decode on the captured pins
  cycle_t state_q;
  logic [ADDR_W-1:2] upper_q;
  logic proc_start;
  logic ctrl_start;
  logic start;
  logic selected;
  logic advance;
  logic access;
  logic write_block;
  lane_mask_t wr_lane;
  logic do_read;
  low_t cur_low;
  low_t next_low;
  logic [ADDR_W-1:0] acc_addr;

  assign proc_start = !cap_pstrb_n_q && !cap_ce_n_q;
  // processor strobe wins when both strobes are low in one cycle with the primary select low; with it high the controller strobe starts
  assign ctrl_start = !cap_cstrb_n_q && !proc_start;
  assign start = proc_start || ctrl_start;
  assign selected = !cap_ce_n_q && cap_sel2_q && (!HAS_THIRD_SELECT || !cap_sel3_n_q);
  assign advance = !start && state_q == ST_ACTIVE && !cap_step_n_q;
  assign access = !sleep && (start ? selected : state_q == ST_ACTIVE);
  assign write_block = !cap_gate_n_q && cap_bw_n_q != `SRAM_LANES_ALL;
  assign wr_lane = (proc_start || !access) ? `SRAM_LANES_NONE :
    ({`SRAM_LANES{!cap_allw_n_q}} | ({`SRAM_LANES{!cap_gate_n_q}} & ~cap_bw_n_q));
  assign do_read = access && wr_lane == `SRAM_LANES_NONE;
  assign acc_addr = start ? cap_addr_q : {upper_q, advance ? next_low : cur_low};

  burst_counter u_burst_counter (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .load_i(start && !sleep),
    .load_low_i(cap_addr_q[1:0]),
    .step_i(advance && !sleep),
    .linear_i(linear),
    .low_o(cur_low),
    .next_low_o(next_low)
  );

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= ST_DESEL;
      upper_q <= '0;
    end else if (sleep) begin
      state_q <= ST_DESEL;
    end else if (start) begin
      state_q <= selected ? ST_ACTIVE : ST_DESEL;
      upper_q <= cap_addr_q[ADDR_W-1:2];
    end
  end

  // storage has no reset so it survives sleep and reset alike
  logic [`SRAM_DATA_W-1:0] mem_q [DEPTH];

  always_ff @(posedge CLK_I) begin
    for (int i = 0; i < `SRAM_LANES; i++) begin
      if (wr_lane[i]) begin
        mem_q[acc_addr][i*`SRAM_LANE_W +: `SRAM_LANE_W] <= cap_data_q[i*`SRAM_LANE_W +: `SRAM_LANE_W];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      DATA_O <= '0;
    end else if (do_read) begin
      DATA_O <= mem_q[acc_addr];
    end
  end

  logic rd_valid_q;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= do_read || (rd_valid_q && !start && !advance && state_q == ST_ACTIVE);
    end
  end

  // drivers follow the enable even while held read data stands
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      DATA_OE_O <= `SRAM_LANES_NONE;
    end else if (oe_n || sleep || write_block) begin
      DATA_OE_O <= `SRAM_LANES_NONE;
    end else begin
      DATA_OE_O <= {`SRAM_LANES{do_read || (rd_valid_q && !start && !advance && state_q == ST_ACTIVE)}};
    end
  end

  a_proc_gated_select: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    cap_ce_n_q |-> !proc_start)
    else $error("processor strobe acted with select high");

  a_proc_starts_read: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (proc_start && selected && !sleep) |-> (wr_lane == `SRAM_LANES_NONE ##1 state_q == ST_ACTIVE))
    else $error("processor strobe did not start a read");

  a_global_write_all: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (access && !proc_start && !cap_allw_n_q) |-> wr_lane == `SRAM_LANES_ALL)
    else $error("global write missed a lane");

  a_gate_lane_map: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (access && !proc_start && cap_allw_n_q) |-> wr_lane == (cap_gate_n_q ? `SRAM_LANES_NONE : ~cap_bw_n_q))
    else $error("lane writes not gated correctly");

  a_hiz_on_write: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    write_block |=> DATA_OE_O == `SRAM_LANES_NONE)
    else $error("data driven during a byte write");

  a_oe_turns_off: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (OUTPUT_ENABLE_N_I [*3]) |=> DATA_OE_O == `SRAM_LANES_NONE)
    else $error("drivers on while output enable high");

  a_sleep_standby: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    sleep |=> (state_q == ST_DESEL && DATA_OE_O == `SRAM_LANES_NONE))
    else $error("device active during sleep");

  a_wait_holds_addr: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (state_q == ST_ACTIVE && !start && cap_step_n_q && !sleep) |=> $stable(cur_low))
    else $error("burst address moved in a wait cycle");

  a_start_loads_addr: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (start && !sleep) |=> {upper_q, cur_low} == $past(cap_addr_q))
    else $error("new address not loaded");

  a_deselect_ctrl: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (ctrl_start && !cap_sel2_q) |=> state_q == ST_DESEL)
    else $error("selected with second select low");

endmodule

`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none

module host_model (
  input wire logic clk_i,
  output logic [3:0] addr_o,
  output logic cen_o,
  output logic sel2_o,
  output logic ce3n_o,
  output logic psn_o,
  output logic csn_o,
  output logic stepn_o,
  output logic [3:0] lwn_o,
  output logic gaten_o,
  output logic gwn_o,
  output logic oen_o,
  output logic order_o,
  output logic sleep_o,
  output logic [35:0] d_o
);
  initial begin
    addr_o = 4'h0;
    psn_o = 1'b1;
    csn_o = 1'b1;
    stepn_o = 1'b1;
    lwn_o = 4'hF;
    gaten_o = 1'b1;
    gwn_o = 1'b1;
    cen_o = 1'b0;
    sel2_o = 1'b1;
    ce3n_o = 1'b0;
    oen_o = 1'b0;
    order_o = 1'b0;
    sleep_o = 1'b0;
    d_o = 36'h0;
  end

  // selects, output enable, order and sleep stay put until the next call
  task automatic pins(input logic [2:0] sel, input logic oe_n, ord, slp);
    cen_o = sel[2];
    sel2_o = sel[1];
    ce3n_o = sel[0];
    oen_o = oe_n;
    order_o = ord;
    sleep_o = slp;
  endtask

  // pins change just after an edge and hold until the next capture edge
  task automatic cyc(input logic [3:0] a, input logic p, c, s, input logic [3:0] lw, input logic g, w,
      input logic [35:0] d);
    addr_o = a;
    psn_o = p;
    csn_o = c;
    stepn_o = s;
    lwn_o = lw;
    gaten_o = g;
    gwn_o = w;
    // outside a write the data lines toggle so a stale value cannot pass
    d_o = (!w || (!g && lw != 4'hF)) ? d : ~d_o;
    @(posedge clk_i);
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(4'h0, 1'b1, 1'b1, 1'b1, 4'hF, 1'b1, 1'b1, 36'h0);
  endtask
endmodule

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk, rstn, cen, sel2, ce3n, psn, csn, stepn, gaten, gwn, oen, order, sleep;
  logic [3:0] addr, lwn, oe;
  logic [35:0] din, dout;
  logic [35:0] mem [4];
  int error_cnt = 0;
  int check_count = 0;

  host_model host (.clk_i(clk), .addr_o(addr), .cen_o(cen), .sel2_o(sel2), .ce3n_o(ce3n), .psn_o(psn),
    .csn_o(csn), .stepn_o(stepn), .lwn_o(lwn), .gaten_o(gaten), .gwn_o(gwn), .oen_o(oen),
    .order_o(order), .sleep_o(sleep), .d_o(din));

  sync_burst_sram_pin_control #(.ADDR_W(4), .HAS_THIRD_SELECT(1'b1)) DUT (.CLK_I(clk), .RSTN_I(rstn),
    .ADDR_I(addr), .CHIP_SELECT_N_I(cen), .SECOND_SELECT_HI_I(sel2), .THIRD_SELECT_N_I(ce3n),
    .PROC_ADDR_STROBE_N_I(psn), .CTRL_ADDR_STROBE_N_I(csn), .BURST_STEP_N_I(stepn),
    .LANE0_WRITE_N_I(lwn[0]), .LANE1_WRITE_N_I(lwn[1]), .LANE2_WRITE_N_I(lwn[2]),
    .LANE3_WRITE_N_I(lwn[3]), .BYTE_WRITE_GATE_N_I(gaten), .ALL_LANES_WRITE_N_I(gwn),
    .OUTPUT_ENABLE_N_I(oen), .BURST_ORDER_I(order), .SLEEP_REQUEST_I(sleep), .DATA_I(din),
    .DATA_O(dout), .DATA_OE_O(oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk_d(input logic [35:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL read data expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_e(input logic [3:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL driver enable expected %h seen %h", e, g);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // controller strobe, then three continuation writes of the full word
  task automatic wr_burst;
    for (int i = 0; i < 4; i++) begin
      mem[i] = 36'(36'h123456789 * (i + 1));
      host.cyc(4'h0, 1'b1, i != 0, i == 0, 4'hF, 1'b1, 1'b0, mem[i]);
    end
    host.idle(1);
    chk_e(4'h0, oe);
  endtask

  // external low bits stay 0 after the strobe, so only the counter can move them
  task automatic rd_burst(input logic [1:0] b, input logic lin);
    logic [1:0] c;
    host.cyc({2'h0, b}, 1'b0, 1'b1, 1'b1, 4'hF, 1'b1, 1'b1, 36'h0);
    for (int k = 0; k < 5; k++) begin
      host.cyc(4'h0, 1'b1, 1'b1, k == 1, 4'hF, 1'b1, 1'b1, 36'h0);
      c = 2'(k - (k >= 2));
      chk_d(mem[lin ? 2'(b + c) : b ^ c], dout);
      if (k == 2)
        chk_e(4'hF, oe);
    end
  endtask

  task automatic lanes;
    for (int i = 0; i < 4; i++) begin
      host.cyc(4'(i), 1'b1, 1'b0, 1'b1, ~(4'h1 << i), 1'b0, 1'b1, {4{9'h1FF}});
      mem[i][9*i+:9] = 9'h1FF;
      host.idle(1);
      chk_e(4'h0, oe);
    end
    host.cyc(4'h0, 1'b1, 1'b0, 1'b1, 4'h0, 1'b1, 1'b1, 36'h0);
    host.idle(1);
    chk_d(mem[0], dout);
    chk_e(4'hF, oe);
  endtask

  task automatic ctl;
    logic [2:0] sel [4] = '{3'b110, 3'b000, 3'b011, 3'b010};
    host.pins(3'b010, 1'b1, 1'b1, 1'b0);
    host.idle(3);
    chk_e(4'h0, oe);
    host.pins(3'b010, 1'b0, 1'b1, 1'b0);
    host.idle(3);
    chk_e(4'hF, oe);
    host.pins(3'b010, 1'b0, 1'b1, 1'b1);
    host.idle(3);
    chk_e(4'h0, oe);
    host.pins(3'b010, 1'b0, 1'b1, 1'b0);
    host.idle(3);
    chk_e(4'h0, oe);
    for (int j = 0; j < 4; j++) begin
      host.pins(sel[j], 1'b0, 1'b1, 1'b0);
      host.cyc(4'h0, 1'b0, 1'b1, 1'b1, 4'hF, 1'b1, 1'b1, 36'h0);
      host.idle(1);
      chk_e(j == 3 ? 4'hF : 4'h0, oe);
    end
    chk_d(mem[0], dout);
    // a processor strobe with global write low must read; the wait read after it proves no write
    host.cyc(4'h3, 1'b0, 1'b1, 1'b1, 4'hF, 1'b1, 1'b0, 36'h0);
    host.idle(2);
    chk_d(mem[3], dout);
    chk_e(4'hF, oe);
    // primary select high: the strobe is no start, so the burst only waits and keeps driving
    host.pins(3'b110, 1'b0, 1'b1, 1'b0);
    host.cyc(4'h1, 1'b0, 1'b1, 1'b1, 4'hF, 1'b1, 1'b1, 36'h0);
    host.idle(1);
    chk_d(mem[3], dout);
    chk_e(4'hF, oe);
    host.pins(3'b000, 1'b0, 1'b1, 1'b0);
    host.cyc(4'h2, 1'b1, 1'b0, 1'b1, 4'hF, 1'b1, 1'b1, 36'h0);
    host.idle(1);
    chk_e(4'h0, oe);
    host.pins(3'b010, 1'b0, 1'b1, 1'b0);
    host.cyc(4'h2, 1'b1, 1'b0, 1'b1, 4'hF, 1'b1, 1'b1, 36'h0);
    host.idle(1);
    chk_d(mem[2], dout);
    chk_e(4'hF, oe);
  endtask

  initial begin
    #(2000 * 25);
    error_cnt++;
    wrap_up();
  end

  initial begin
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_e(4'h0, oe);
    chk_d(36'h0, dout);
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    host.idle(3);
    wr_burst();
    rd_burst(2'h2, 1'b1);
    lanes();
    rd_burst(2'h3, 1'b1);
    host.pins(3'b010, 1'b0, 1'b1, 1'b0);
    host.idle(3);
    rd_burst(2'h1, 1'b0);
    ctl();
    wrap_up();
  end
endmodule

`default_nettype wire
